// file: hdl/supervisor_pkg.sv
// supervisor package: register map, fields, reset values, timing
// assumes a 20 MHz aclk and a 32-bit AXI4-Lite register bus
package supervisor_pkg;
    localparam int unsigned clk_hz = 20000000;
    localparam logic [7:0] addr_ctrl = 8'h00;
    localparam logic [7:0] addr_cause = 8'h04;
    localparam logic [7:0] addr_wdg_load = 8'h08;
    localparam logic [7:0] addr_wdg_count = 8'h0c;
    localparam logic [7:0] addr_wdg_kick = 8'h10;
    localparam logic [7:0] addr_brown = 8'h14;
    localparam logic [7:0] addr_tamper = 8'h18;
    localparam logic [7:0] addr_debug = 8'h1c;
    // control register fields
    localparam int ctrl_wdg_en = 0;
    localparam int ctrl_wdg_mode = 1;
    localparam int ctrl_io_lvd_rst_off = 2;
    localparam int ctrl_lvd_off = 3;
    localparam int ctrl_tamper_en = 4;
    localparam int ctrl_tamper_edge = 5;
    localparam int ctrl_tamper_rise = 6;
    localparam int ctrl_batt_sram = 7;
    localparam int ctrl_presc_lsb = 8;
    localparam logic [15:0] ctrl_reset = 16'h0000;
    // cause register fields
    localparam int cause_wdg = 0;
    localparam int cause_lvd = 1;
    localparam int cause_pin = 2;
    localparam int cause_dbg = 3;
    localparam logic [3:0] cause_reset = 4'h0;
    localparam logic [15:0] wdg_load_reset = 16'hffff;
    localparam logic [15:0] wdg_terminal = 16'h0000;
    localparam logic [31:0] wdg_kick_key = 32'h0000_5a5a;
    localparam logic [31:0] boot_address = 32'h0000_0000;
    // times in nanoseconds
    localparam int unsigned t_por_ns = 1000000;
    localparam int unsigned t_rinmin_ns = 500;
    localparam int unsigned por_cycles = (t_por_ns * (clk_hz / 1000000) + 999) / 1000;
    localparam int unsigned rinmin_cycles = (t_rinmin_ns * (clk_hz / 1000000) + 999) / 1000;
    localparam int unsigned debounce_cycles = 4;
    localparam logic [1:0] axi_okay = 2'b00;
    localparam logic [1:0] axi_slverr = 2'b10;

    typedef struct packed {
        logic core_dropout;
        logic io_dropout;
        logic core_sag;
        logic io_sag;
        logic io_level_high;
    } supply_status_t;

    typedef struct packed {
        logic global_reset;
        logic system_reset;
    } reset_req_t;

    typedef enum logic [2:0] {
        st_wait_supply = 3'b001,
        st_hold = 3'b010,
        st_run = 3'b100
    } seq_state_t;
endpackage

// file: hdl/system_supervisor_reset.sv
// system supervisor: turns supply, watchdog, pin, debug and tamper inputs into resets and events
// assumes supply monitor bits and debug inputs synchronous to aclk, reset and tamper pins are synchronised here; analog parts, calendar unit sit outside
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module system_supervisor_reset #(
    parameter int unsigned por_count = supervisor_pkg::por_cycles,
    parameter int unsigned wdg_width = 16,
    parameter int unsigned presc_width = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire supervisor_pkg::supply_status_t supply,
    input wire logic power_up,
    input wire logic ext_reset_in_n,
    input wire logic debug_mode,
    input wire logic debug_reset_cmd,
    input wire logic tamper_in,
    output supervisor_pkg::reset_req_t reset_out,
    output logic board_reset_out_n,
    output logic brownout_irq,
    output logic io_lvd_level_high,
    output logic tamper_capture,
    output logic sram_standby_cut,
    output logic battery_powers_sram,
    output logic [31:0] boot_addr
);
    import supervisor_pkg::*;

    localparam int cnt_w = $clog2(por_count + 1);
    logic [15:0] ctrl;
    logic [3:0] cause;
    logic [wdg_width-1:0] wdg_load;
    logic [wdg_width-1:0] wdg_count;
    logic [presc_width-1:0] presc_cnt;
    logic [1:0] brown_mask;
    logic [1:0] brown_flag;
    logic tamper_flag;
    seq_state_t state;
    logic [cnt_w-1:0] por_cnt;
    logic global_reset;
    logic system_reset;
    logic next_global;
    logic next_system;
    logic low_voltage_detector;
    logic wdg_expire;
    logic pin_reset;
    logic wdg_kick;
    logic [1:0] pin_sync;
    logic [1:0] tmp_sync;
    logic [2:0] pin_db;
    logic [2:0] tmp_db;
    logic pin_clean;
    logic tmp_clean;
    logic tmp_prev;
    logic tamper_event;
    logic [15:0] pin_low_cnt;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // byte-lane merge of a register image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_write(input logic [7:0] a, input logic [7:0] target);
        return a[7:2] == target[7:2];
    endfunction

    // power-up condition combined with dropout detection
    always_comb begin
        low_voltage_detector = supply.core_dropout;
        if (!ctrl[ctrl_lvd_off] && !ctrl[ctrl_io_lvd_rst_off]) begin
            low_voltage_detector = supply.core_dropout | supply.io_dropout;
        end
        next_global = power_up | low_voltage_detector;
        next_system = wdg_expire | pin_reset | (debug_mode & debug_reset_cmd);
    end

    // power-on sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn || next_global) begin
            state <= st_wait_supply;
            por_cnt <= '0;
        end else begin
            unique case (state)
                st_wait_supply: begin
                    if (!supply.core_dropout && !supply.io_dropout) begin
                        state <= st_hold;
                    end
                end
                st_hold: begin
                    if (por_cnt == cnt_w'(por_count - 1)) begin
                        state <= st_run;
                    end else begin
                        por_cnt <= por_cnt + 1'b1;
                    end
                end
                st_run: begin
                    if (next_system) begin
                        state <= st_hold;
                        por_cnt <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_reset <= 1'b1;
            system_reset <= 1'b1;
            board_reset_out_n <= 1'b0;
            boot_addr <= boot_address;
        end else begin
            global_reset <= next_global || state == st_wait_supply;
            system_reset <= next_global || next_system || state != st_run;
            board_reset_out_n <= !(next_global || next_system) && state == st_run;
            boot_addr <= boot_address;
        end
    end
    assign reset_out = '{global_reset: global_reset, system_reset: system_reset};

    // pin and tamper synchronisers and debounce
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync <= 2'b11;
            tmp_sync <= 2'b00;
            pin_db <= 3'b111;
            tmp_db <= 3'b000;
            pin_clean <= 1'b1;
            tmp_clean <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[0], ext_reset_in_n};
            tmp_sync <= {tmp_sync[0], tamper_in};
            pin_db <= {pin_db[1:0], pin_sync[1]};
            tmp_db <= {tmp_db[1:0], tmp_sync[1]};
            if (&pin_db || ~|pin_db) begin
                pin_clean <= pin_db[2];
            end
            if (&tmp_db || ~|tmp_db) begin
                tmp_clean <= tmp_db[2];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_low_cnt <= '0;
            pin_reset <= 1'b0;
        end else begin
            pin_reset <= 1'b0;
            if (pin_clean) begin
                pin_low_cnt <= '0;
            end else if (pin_low_cnt != 16'(rinmin_cycles)) begin
                pin_low_cnt <= pin_low_cnt + 1'b1;
                pin_reset <= pin_low_cnt == 16'(rinmin_cycles - 1);
            end
        end
    end

    // register writes: aw and w taken in any order, response after both
    assign do_write = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= axi_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[7:2] > addr_debug[7:2]) ? axi_slverr : axi_okay;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold;
    assign s_axi_wready = !w_hold;
    assign wdg_kick = do_write && is_write(aw_addr, addr_wdg_kick) && w_data == wdg_kick_key;

    // control: clock-side fields survive system reset, watchdog enable never does
    always_ff @(posedge aclk) begin
        if (!aresetn || global_reset) begin
            ctrl <= ctrl_reset;
        end else if (system_reset) begin
            ctrl[ctrl_wdg_en] <= 1'b0;
        end else if (do_write && is_write(aw_addr, addr_ctrl)) begin
            ctrl <= 16'(merge({16'h0, ctrl}, w_data, w_strb));
        end
    end

    // reset cause: only power-up or aresetn clears, clear wins over set
    always_ff @(posedge aclk) begin
        if (!aresetn || power_up) begin
            cause <= cause_reset;
        end else begin
            if (wdg_expire) begin
                cause[cause_wdg] <= 1'b1;
            end
            if (low_voltage_detector) begin
                cause[cause_lvd] <= 1'b1;
            end
            if (pin_reset) begin
                cause[cause_pin] <= 1'b1;
            end
            if (debug_mode && debug_reset_cmd) begin
                cause[cause_dbg] <= 1'b1;
            end
        end
    end

    // watchdog counter and prescaler
    always_ff @(posedge aclk) begin
        if (!aresetn || system_reset) begin
            wdg_load <= wdg_load_reset;
            wdg_count <= wdg_load_reset;
            presc_cnt <= '0;
            wdg_expire <= 1'b0;
        end else begin
            wdg_expire <= 1'b0;
            if (do_write && is_write(aw_addr, addr_wdg_load)) begin
                wdg_load <= wdg_width'(merge(32'(wdg_load), w_data, w_strb));
            end
            if (wdg_kick) begin
                wdg_count <= wdg_load;
                presc_cnt <= '0;
            end else if (ctrl[ctrl_wdg_en]) begin
                if (presc_cnt == ctrl[ctrl_presc_lsb +: presc_width]) begin
                    presc_cnt <= '0;
                    if (wdg_count == wdg_terminal) begin
                        wdg_count <= wdg_load;
                    end else begin
                        wdg_count <= wdg_count - 1'b1;
                        wdg_expire <= ctrl[ctrl_wdg_mode] &&
                                      wdg_count == wdg_terminal + 1'b1;
                    end
                end else begin
                    presc_cnt <= presc_cnt + 1'b1;
                end
            end
        end
    end

    // brown-out warnings and tamper
    always_ff @(posedge aclk) begin
        if (!aresetn || system_reset) begin
            brown_mask <= 2'b00;
            brown_flag <= 2'b00;
            brownout_irq <= 1'b0;
            tamper_flag <= 1'b0;
            tmp_prev <= 1'b0;
            tamper_capture <= 1'b0;
            sram_standby_cut <= 1'b0;
        end else begin
            if (do_write && is_write(aw_addr, addr_brown)) begin
                brown_mask <= w_data[1:0];
                brown_flag <= (brown_flag & ~w_data[9:8]) | {supply.io_sag, supply.core_sag};
            end else begin
                brown_flag <= brown_flag | {supply.io_sag, supply.core_sag};
            end
            brownout_irq <= |(brown_flag & brown_mask);
            tmp_prev <= tmp_clean;
            tamper_capture <= tamper_event;
            if (tamper_event) begin
                tamper_flag <= 1'b1;
                sram_standby_cut <= 1'b1;
            end else if (do_write && is_write(aw_addr, addr_tamper) && w_data[0]) begin
                tamper_flag <= 1'b0;
            end
        end
    end
    always_comb begin
        if (!ctrl[ctrl_tamper_en]) begin
            tamper_event = 1'b0;
        end else if (!ctrl[ctrl_tamper_edge]) begin
            tamper_event = tmp_clean && !tamper_flag;
        end else begin
            tamper_event = (tmp_clean != tmp_prev) && (tmp_clean == ctrl[ctrl_tamper_rise]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_lvd_level_high <= 1'b0;
            battery_powers_sram <= 1'b0;
        end else begin
            io_lvd_level_high <= supply.io_level_high;
            battery_powers_sram <= ctrl[ctrl_batt_sram];
        end
    end

    // reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= axi_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= axi_okay;
            unique case (s_axi_araddr[7:2])
                addr_ctrl[7:2]: s_axi_rdata <= {16'h0, ctrl};
                addr_cause[7:2]: s_axi_rdata <= {28'h0, cause};
                addr_wdg_load[7:2]: s_axi_rdata <= {16'h0, wdg_load};
                addr_wdg_count[7:2]: s_axi_rdata <= {16'h0, wdg_count};
                addr_wdg_kick[7:2]: s_axi_rdata <= '0;
                addr_brown[7:2]: s_axi_rdata <= {22'h0, brown_flag, 6'h0, brown_mask};
                addr_tamper[7:2]: s_axi_rdata <= {31'h0, tamper_flag};
                addr_debug[7:2]: s_axi_rdata <= {30'h0, io_lvd_level_high, debug_mode};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= axi_slverr;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

// file: verification/board_model.sv
// board side model: supply monitors, reset pin with pull-up, tamper switch, debug probe
// assumes tasks are called from the aclk domain of the bench
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input wire logic aclk,
    output var supervisor_pkg::supply_status_t supply,
    output logic power_up,
    output logic ext_reset_in_n,
    output logic debug_mode,
    output logic debug_reset_cmd,
    output logic tamper_in
);
    import supervisor_pkg::*;
    initial begin
        supply = '0;
        power_up = 1'b1;
        ext_reset_in_n = 1'b1;
        debug_mode = 1'b0;
        debug_reset_cmd = 1'b0;
        tamper_in = 1'b0;
    end
    task automatic set_supply(input supply_status_t s);
        @(posedge aclk);
        supply <= s;
    endtask
    task automatic set_power(input logic v);
        @(posedge aclk);
        power_up <= v;
    endtask
    task automatic set_tamper(input logic v);
        @(posedge aclk);
        tamper_in <= v;
    endtask
    // released pin returns to the pull-up level
    task automatic hold_pin(input int n);
        @(posedge aclk);
        ext_reset_in_n <= 1'b0;
        repeat (n) @(posedge aclk);
        ext_reset_in_n <= 1'b1;
    endtask
    // probe reset command
    task automatic dbg_reset(input logic mode);
        @(posedge aclk);
        debug_mode <= mode;
        debug_reset_cmd <= 1'b1;
        repeat (2) @(posedge aclk);
        debug_mode <= 1'b0;
        debug_reset_cmd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/system_supervisor_reset_asserts.sv
// checker: reset causes, reset output timing, tamper outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module system_supervisor_reset_asserts
    import supervisor_pkg::*;
#(
    parameter int unsigned por_count = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire supervisor_pkg::supply_status_t supply,
    input wire logic power_up,
    input wire logic ext_reset_in_n,
    input wire logic debug_mode,
    input wire logic debug_reset_cmd,
    input wire supervisor_pkg::reset_req_t reset_out,
    input wire logic board_reset_out_n,
    input wire logic tamper_capture,
    input wire logic sram_standby_cut,
    input wire logic io_lvd_level_high,
    input wire logic [31:0] boot_addr
);
    int unsigned low_cnt;
    int unsigned pin_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // board reset output low length
    always_ff @(posedge aclk) begin
        if (!aresetn || board_reset_out_n) low_cnt <= '0;
        else low_cnt <= low_cnt + 1;
    end
    // reset pin low length, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn || ext_reset_in_n) pin_cnt <= '0;
        else if (pin_cnt < 31) pin_cnt <= pin_cnt + 1;
    end
    property p_core; supply.core_dropout |-> ##[1:3] reset_out.global_reset; endproperty
    property p_power; power_up |-> ##[1:3] reset_out.global_reset; endproperty
    property p_gr_sr; reset_out.global_reset |-> reset_out.system_reset; endproperty
    property p_board; $rose(board_reset_out_n) |-> low_cnt >= por_count - 1; endproperty
    property p_pin; pin_cnt == 24 |-> reset_out.system_reset; endproperty
    property p_dbg; debug_mode && debug_reset_cmd |-> ##[1:4] reset_out.system_reset; endproperty
    property p_tpulse; tamper_capture |=> !tamper_capture; endproperty
    property p_tcut; tamper_capture |-> ##[0:1] sram_standby_cut; endproperty
    property p_sticky; sram_standby_cut && !reset_out.system_reset |=> sram_standby_cut || reset_out.system_reset;
    endproperty
    property p_io; supply.io_level_high [*2] |-> io_lvd_level_high; endproperty
    property p_boot; boot_addr == boot_address; endproperty
    a_core: assert property (p_core) else $error("core dropout without global reset");
    a_power: assert property (p_power) else $error("power-up without global reset");
    a_gr_sr: assert property (p_gr_sr) else $error("global reset without system reset");
    a_board: assert property (p_board) else $error("board reset output released early");
    a_pin: assert property (p_pin) else $error("long pin low without system reset");
    a_dbg: assert property (p_dbg) else $error("debug command without system reset");
    a_tpulse: assert property (p_tpulse) else $error("capture pulse longer than one cycle");
    a_tcut: assert property (p_tcut) else $error("standby supply not cut on capture");
    a_sticky: assert property (p_sticky) else $error("standby cut dropped without reset");
    a_io: assert property (p_io) else $error("io level selection not followed");
    a_boot: assert property (p_boot) else $error("boot address not zero");
    c_pin: cover property (pin_cnt == 24);
    c_tamper: cover property (tamper_capture);
    c_board: cover property ($rose(board_reset_out_n));
endmodule
`default_nettype wire

// file: verification/test_system_supervisor_reset.sv
// bench: bus tasks, reset scenarios, scoreboard on bus answers
// assumes board_model on the pins and the checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module test_system_supervisor_reset;
    import supervisor_pkg::*;
    localparam int unsigned por = 20;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, boot_addr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    supply_status_t supply;
    reset_req_t reset_out;
    logic power_up, ext_reset_in_n, debug_mode, debug_reset_cmd, tamper_in, board_reset_out_n;
    logic brownout_irq, io_lvd_level_high, tamper_capture, sram_standby_cut, battery_powers_sram;
    note_t rq[$];
    logic [1:0] bq[$];
    int failures = 0;
    int n_compared = 0;
    system_supervisor_reset #(.por_count(por)) u_system_supervisor_reset (.*);
    board_model u_board_model (.*);
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk(input string n, input logic e, input logic g);
        cmp(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic lim(input int k, input int n);
        if (k >= n) begin
            chk("wait_done", 1'b1, 1'b0);
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        logic aw, w, b;
        bq.push_back(r);
        @(posedge aclk);
        {aw, w, b} = 3'b111;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= (a == addr_wdg_load) ? 4'h3 : 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (k = 0; k < 60 && (aw || w || b); k++) begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            if (s_axi_bvalid) b = 1'b0;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, b};
        end
        lim(k, 60);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        int k;
        logic ar, rr;
        rq.push_back({d & m, m, r});
        @(posedge aclk);
        {ar, rr} = 2'b11;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (k = 0; k < 60 && (ar || rr); k++) begin
            @(posedge aclk);
            if (s_axi_arready) ar = 1'b0;
            if (s_axi_rvalid) rr = 1'b0;
            {s_axi_arvalid, s_axi_rready} <= {ar, rr};
        end
        lim(k, 60);
    endtask
    // wait for system reset, compare both levels
    task automatic hit(input logic sys, input logic glob, input int n);
        int k;
        for (k = 0; k < n && reset_out.system_reset !== 1'b1; k++) @(posedge aclk);
        @(posedge aclk);
        chk("system_reset", sys, reset_out.system_reset);
        chk("global_reset", glob, reset_out.global_reset);
    endtask
    task automatic rel();
        int k;
        for (k = 0; k < por + 300 && board_reset_out_n !== 1'b1; k++) @(posedge aclk);
        lim(k, por + 300);
        @(posedge aclk);
    endtask
    task automatic cap();
        int k;
        for (k = 0; k < 30 && tamper_capture !== 1'b1; k++) @(posedge aclk);
        lim(k, 30);
        @(posedge aclk);
    endtask
    always @(posedge aclk) begin
        note_t e;
        if (s_axi_bvalid && s_axi_bready)
            cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            cmp("rdata", e.d, s_axi_rdata & e.m);
            cmp("rresp", {30'h0, e.r}, {30'h0, s_axi_rresp});
        end
    end
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        int ld, ps;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        void'($urandom(32'h6b84));
        repeat (8) @(posedge aclk);
        u_board_model.set_power(1'b0);
        repeat (7) @(posedge aclk);
        aresetn <= 1'b1;
        rel();
        cmp("boot_addr", boot_address, boot_addr);
        rd(addr_ctrl, 32'h0, 32'hffff, axi_okay);
        rd(addr_cause, 32'h0, 32'hf, axi_okay);
        rd(addr_wdg_load, {16'h0, wdg_load_reset}, 32'hffff, axi_okay);
        rd(8'h20, 32'h0, 32'hffff_ffff, axi_slverr);
        wr(8'h24, 32'h1, axi_slverr);
        $display("test registers done");
        wr(addr_brown, 32'h3, axi_okay);
        u_board_model.set_supply(5'b00111);
        repeat (6) @(posedge aclk);
        chk("brownout_irq", 1'b1, brownout_irq);
        chk("io_lvd_level_high", 1'b1, io_lvd_level_high);
        rd(addr_brown, 32'h303, 32'h303, axi_okay);
        wr(addr_brown, 32'h0, axi_okay);
        repeat (3) @(posedge aclk);
        chk("brownout_irq", 1'b0, brownout_irq);
        u_board_model.set_supply(5'b00001);
        wr(addr_brown, 32'h300, axi_okay);
        rd(addr_brown, 32'h0, 32'h303, axi_okay);
        $display("test brownout done");
        ld = $urandom_range(9, 6);
        ps = $urandom_range(2, 0);
        wr(addr_wdg_load, ld, axi_okay);
        wr(addr_ctrl, 32'h1, axi_okay);
        hit(1'b0, 1'b0, 40);
        wr(addr_ctrl, {16'h0, ps[7:0], 8'h02}, axi_okay);
        wr(addr_wdg_kick, wdg_kick_key, axi_okay);
        wr(addr_ctrl, {16'h0, ps[7:0], 8'h03}, axi_okay);
        repeat (ld * (ps + 1) - 5) @(posedge aclk);
        chk("system_reset", 1'b0, reset_out.system_reset);
        hit(1'b1, 1'b0, 12);
        rel();
        rd(addr_ctrl, 32'h2, 32'h3, axi_okay);
        rd(addr_cause, 32'h1, 32'hf, axi_okay);
        $display("test watchdog done");
        u_board_model.hold_pin(3);
        hit(1'b0, 1'b0, 20);
        u_board_model.hold_pin(30);
        hit(1'b1, 1'b0, 20);
        rel();
        rd(addr_cause, 32'h5, 32'hf, axi_okay);
        u_board_model.dbg_reset(1'b0);
        hit(1'b0, 1'b0, 10);
        u_board_model.dbg_reset(1'b1);
        hit(1'b1, 1'b0, 10);
        rel();
        rd(addr_cause, 32'hd, 32'hf, axi_okay);
        $display("test pin and debug done");
        wr(addr_ctrl, 32'hf0, axi_okay);
        u_board_model.set_tamper(1'b1);
        cap();
        chk("sram_standby_cut", 1'b1, sram_standby_cut);
        chk("battery_powers_sram", 1'b1, battery_powers_sram);
        rd(addr_tamper, 32'h1, 32'h1, axi_okay);
        wr(addr_tamper, 32'h1, axi_okay);
        wr(addr_ctrl, 32'h30, axi_okay);
        u_board_model.set_tamper(1'b0);
        cap();
        $display("test tamper done");
        wr(addr_ctrl, 32'h04, axi_okay);
        u_board_model.set_supply(5'b01001);
        hit(1'b0, 1'b0, 20);
        u_board_model.set_supply(5'b00001);
        wr(addr_ctrl, 32'h0, axi_okay);
        u_board_model.set_supply(5'b01001);
        hit(1'b1, 1'b1, 20);
        u_board_model.set_supply(5'b00001);
        rel();
        rd(addr_cause, 32'hf, 32'hf, axi_okay);
        wr(addr_ctrl, 32'h08, axi_okay);
        u_board_model.set_supply(5'b10001);
        hit(1'b1, 1'b1, 20);
        u_board_model.set_supply(5'b00001);
        rel();
        u_board_model.set_power(1'b1);
        hit(1'b1, 1'b1, 20);
        u_board_model.set_power(1'b0);
        rel();
        rd(addr_cause, 32'h0, 32'hf, axi_okay);
        rd(addr_ctrl, 32'h0, 32'hffff, axi_okay);
        $display("test dropout done");
        close_out();
    end
endmodule
bind system_supervisor_reset system_supervisor_reset_asserts #(.por_count(por_count)) u_asserts (.*);
`default_nettype wire
